// >>> logic/timer_map.svh
// Register offsets, field positions, reset values and codes of the timer control block.
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TMR_CTRL_OFS      8'h00
`define TMR_IRQ_EN_OFS    8'h0C
`define TMR_IRQ_STAT_OFS  8'h10
`define TMR_EVENT_OFS     8'h14
`define TMR_COUNT_OFS     8'h24
`define TMR_PSC_OFS       8'h28
`define TMR_RELOAD_OFS    8'h2C
`define TMR_CMP_OFS       8'h34
`define TMR_IRQ_CLR_OFS   8'h50

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define TMR_CTRL_RESET    16'h0000
`define TMR_WORD_RESET    16'h0000
`define TMR_RELOAD_RESET  16'hFFFF
`define TMR_CTRL_RW_MASK  16'h03FF
`define TMR_EV_UPDATE_BIT 0
`define TMR_ST_UPDATE_BIT 0
`define TMR_ST_CMP_BIT    1
`define TMR_EN_DMA_BIT    8
`define TMR_CAM_EDGE      2'h0
`define TMR_CAM_DOWN      2'h1
`define TMR_CAM_UP        2'h2
`define TMR_CAM_BOTH      2'h3
`define TMR_DIV_1         2'h0
`define TMR_DIV_2         2'h1
`define TMR_DIV_4         2'h2
`define TMR_DIV_CNT_2     2'h1
`define TMR_DIV_CNT_4     2'h3

`endif

// >>> logic/timer_pkg.sv
// Types shared by the timer control block and its counter core.
package timer_pkg;

  // Control register layout, most significant field first.
  typedef struct packed {
    logic [5:0] reserved;
    logic [1:0] sampling_clock_divider;
    logic       reload_preload_enable;
    logic [1:0] center_align_select;
    logic       count_direction;
    logic       one_shot_enable;
    logic       update_request_source;
    logic       update_inhibit;
    logic       counter_run_enable;
  } ctrl_t;

  // Settings that steer the counter core.
  typedef struct packed {
    logic       run;
    logic       dir_sel;
    logic [1:0] center;
    logic       encoder;
    logic       enc_dir;
  } count_cfg_t;

endpackage

// >>> logic/sample_divider.sv
// Dead-time and filter sampling strobe generator.
`timescale 1ns/1ps
`include "timer_map.svh"

module sample_divider (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] div_i,
  output logic            tick_o
);

  logic [1:0] phase;
  logic [1:0] limit;

  // Code 11 is reserved and behaves like divide by one.
  always_comb begin
    if (div_i == `TMR_DIV_2) begin
      limit = `TMR_DIV_CNT_2;
    end else if (div_i == `TMR_DIV_4) begin
      limit = `TMR_DIV_CNT_4;
    end else begin
      limit = 2'h0;
    end
  end

  // One strobe per sample period, restarting when the phase reaches the limit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase  <= 2'h0;
      tick_o <= 1'b0;
    end else if (phase >= limit) begin
      phase  <= 2'h0;
      tick_o <= 1'b1; // RULE13
    end else begin
      phase  <= phase + 2'h1;
      tick_o <= 1'b0;
    end
  end

  // A divide-by-two period puts one idle cycle between strobes.
  div_two_period_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    (tick_o && div_i == `TMR_DIV_2 && $stable(div_i)) ##1 (div_i == `TMR_DIV_2) |-> !tick_o ##1 tick_o)
    else $error("sample strobe period wrong for divide by two");

endmodule

// >>> logic/count_core.sv
// Prescaler and 16-bit up, down and center-aligned counter.
`timescale 1ns/1ps
`include "timer_map.svh"

module count_core (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  timer_pkg::count_cfg_t     cfg_i,
  input  wire logic [15:0]          reload_i,
  input  wire logic [15:0]          psc_i,
  input  wire logic                 restart_i,
  output logic [15:0]               count_o,
  output logic                      dir_o,
  output logic                      step_o,
  output logic                      wrap_o
);

  logic [15:0] psc_count;
  logic        step_now;
  logic        edge_dir;

  assign step_now = cfg_i.run && (psc_count >= psc_i);
  assign edge_dir = cfg_i.encoder ? cfg_i.enc_dir : cfg_i.dir_sel;

  // Prescaler divides the internal clock; a restart clears it.
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      psc_count <= `TMR_WORD_RESET;
    end else if (step_now) begin
      psc_count <= `TMR_WORD_RESET;
    end else if (cfg_i.run) begin
      psc_count <= psc_count + 16'h0001;
    end
  end

  // Counter proper; wrap marks overflow or underflow.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= `TMR_WORD_RESET;
      dir_o   <= 1'b0;
      step_o  <= 1'b0;
      wrap_o  <= 1'b0;
    end else if (restart_i) begin
      count_o <= (cfg_i.center == `TMR_CAM_EDGE && edge_dir) ? reload_i : `TMR_WORD_RESET;
      dir_o   <= (cfg_i.center == `TMR_CAM_EDGE) ? edge_dir : 1'b0;
      step_o  <= 1'b0;
      wrap_o  <= 1'b0;
    end else begin
      step_o <= step_now;
      wrap_o <= 1'b0;
      if (cfg_i.center == `TMR_CAM_EDGE) begin
        dir_o <= edge_dir;
      end
      if (step_now) begin
        if (cfg_i.center != `TMR_CAM_EDGE) begin
          // Center mode turns round at either end; the direction is hardware's own.
          if (!dir_o && count_o >= reload_i) begin
            dir_o   <= 1'b1;
            count_o <= count_o - 16'h0001;
            wrap_o  <= 1'b1;
          end else if (dir_o && count_o == `TMR_WORD_RESET) begin
            dir_o   <= 1'b0;
            count_o <= count_o + 16'h0001;
            wrap_o  <= 1'b1;
          end else begin
            count_o <= dir_o ? count_o - 16'h0001 : count_o + 16'h0001;
          end
        end else if (!edge_dir) begin
          wrap_o  <= (count_o >= reload_i);
          count_o <= (count_o >= reload_i) ? `TMR_WORD_RESET : count_o + 16'h0001;
        end else begin
          wrap_o  <= (count_o == `TMR_WORD_RESET);
          count_o <= (count_o == `TMR_WORD_RESET) ? reload_i : count_o - 16'h0001;
        end
      end
    end
  end

endmodule

// >>> logic/timer_control_register_one.sv
// Timer control register block with Wishbone slave, update logic and interrupts.
// Function
// RULE1: Software starts counting in external, gated, encoder operation.
// RULE2: Trigger operation sets run enable by hardware.
// RULE3: Update inhibit blocks all update events.
// RULE4: Updates from wrap, software trigger, slave controller.
// RULE5: Update event loads reload, prescaler, compare copies.
// RULE6: Request source zero: every update raises request.
// RULE7: Request source one: only wrap raises request.
// RULE8: One-shot clears run enable at update.
// RULE9: Direction bit; hardware owns it in center/encoder.
// RULE10: Center-align code selects compare flag directions.
// RULE11: Change center-align only while counter stopped.
// RULE12: Reload preload buffers reload until update event.
// RULE13: Sampling divider gives one, two, four clocks.
// RULE14: Reserved control bits read zero, ignore writes.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`include "timer_map.svh"

module timer_control_register_one (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        trigger_mode_i,
  input  wire logic        trigger_i,
  input  wire logic        slave_update_i,
  input  wire logic        encoder_mode_i,
  input  wire logic        encoder_dir_i,
  output logic             irq_o,
  output logic             dma_req_o,
  output logic             update_event_o,
  output logic             dts_tick_o,
  output logic [15:0]      active_reload_o,
  output logic [15:0]      active_prescaler_o,
  output logic [15:0]      active_compare_o
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  timer_pkg::ctrl_t      ctrl;
  timer_pkg::ctrl_t      ctrl_view;
  timer_pkg::count_cfg_t cfg;
  logic [15:0]           reload_pre;
  logic [15:0]           psc_pre;
  logic [15:0]           cmp_pre;
  logic [15:0]           irq_en;
  logic [1:0]            irq_stat;
  logic [1:0]            next_irq_stat;
  logic                  sw_trigger;
  logic [15:0]           count;
  logic                  hw_dir;
  logic                  step;
  logic                  wrap;
  logic                  hw_dir_mode;
  logic                  update_now;
  logic                  request_now;
  logic                  cmp_hit;
  logic                  bus_req;
  logic                  wr_now;
  logic                  trig_set;

  // Byte-lane merge of a 16-bit register with write data.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] sel);
    merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  // --------------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------------
  assign bus_req = cyc_i && stb_i;
  // Writes land on the edge where the master sees ack, matching its commit point.
  assign wr_now  = bus_req && we_i && ack_o;

  // One wait state: ack in the cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req && !ack_o;
    end
  end

  // Read data is captured with ack; unmapped and write-only offsets read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !ack_o && !we_i) begin
      if (adr_i == `TMR_CTRL_OFS) begin
        dat_o <= {16'h0000, ctrl_view}; // RULE14
      end else if (adr_i == `TMR_IRQ_EN_OFS) begin
        dat_o <= {16'h0000, irq_en};
      end else if (adr_i == `TMR_IRQ_STAT_OFS) begin
        dat_o <= {30'h0000_0000, irq_stat};
      end else if (adr_i == `TMR_COUNT_OFS) begin
        dat_o <= {16'h0000, count};
      end else if (adr_i == `TMR_PSC_OFS) begin
        dat_o <= {16'h0000, psc_pre};
      end else if (adr_i == `TMR_RELOAD_OFS) begin
        dat_o <= {16'h0000, reload_pre};
      end else if (adr_i == `TMR_CMP_OFS) begin
        dat_o <= {16'h0000, cmp_pre};
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  // In center-aligned or encoder operation the direction bit shows the counter.
  assign hw_dir_mode = (ctrl.center_align_select != `TMR_CAM_EDGE) || encoder_mode_i;
  always_comb begin
    ctrl_view                 = ctrl;
    ctrl_view.count_direction = hw_dir_mode ? hw_dir : ctrl.count_direction; // RULE9
  end

  assign trig_set = trigger_mode_i && trigger_i;

  // Run enable: a hardware trigger beats the one-shot stop and a software write.
  // Center-align changes are taken at any time; software keeps them to stopped periods.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `TMR_CTRL_RESET;
    end else begin
      if (wr_now && adr_i == `TMR_CTRL_OFS) begin
        ctrl <= merge(ctrl, dat_i, sel_i) & `TMR_CTRL_RW_MASK; // RULE14 RULE1 RULE11
        if (hw_dir_mode) begin
          ctrl.count_direction <= ctrl.count_direction; // RULE9
        end
      end
      if (update_now && ctrl.one_shot_enable) begin
        ctrl.counter_run_enable <= 1'b0; // RULE8
      end
      if (trig_set) begin
        ctrl.counter_run_enable <= 1'b1; // RULE2
      end
    end
  end

  // Software update trigger is a one-cycle pulse; the event register reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_trigger <= 1'b0;
    end else begin
      sw_trigger <= wr_now && adr_i == `TMR_EVENT_OFS && sel_i[0] && dat_i[`TMR_EV_UPDATE_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Update event and preload copies
  // --------------------------------------------------------------------------
  assign update_now  = !ctrl.update_inhibit && (wrap || sw_trigger || slave_update_i); // RULE3 RULE4
  assign request_now = update_now && (wrap || !ctrl.update_request_source); // RULE6 RULE7

  // Prescaler and compare are always buffered; reload only with preload on.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_pre         <= `TMR_RELOAD_RESET;
      psc_pre            <= `TMR_WORD_RESET;
      cmp_pre            <= `TMR_WORD_RESET;
      active_reload_o    <= `TMR_RELOAD_RESET;
      active_prescaler_o <= `TMR_WORD_RESET;
      active_compare_o   <= `TMR_WORD_RESET;
    end else begin
      if (wr_now && adr_i == `TMR_RELOAD_OFS) begin
        reload_pre <= merge(reload_pre, dat_i, sel_i);
      end
      if (wr_now && adr_i == `TMR_PSC_OFS) begin
        psc_pre <= merge(psc_pre, dat_i, sel_i);
      end
      if (wr_now && adr_i == `TMR_CMP_OFS) begin
        cmp_pre <= merge(cmp_pre, dat_i, sel_i);
      end
      if (update_now) begin
        active_reload_o    <= reload_pre; // RULE5
        active_prescaler_o <= psc_pre;    // RULE5
        active_compare_o   <= cmp_pre;    // RULE5
      end
      if (wr_now && adr_i == `TMR_RELOAD_OFS && !ctrl.reload_preload_enable) begin
        active_reload_o <= merge(reload_pre, dat_i, sel_i); // RULE12
      end
    end
  end

  // --------------------------------------------------------------------------
  // Counter and sampling divider
  // --------------------------------------------------------------------------
  assign cfg = '{run:     ctrl.counter_run_enable,
                 dir_sel: ctrl.count_direction,
                 center:  ctrl.center_align_select,
                 encoder: encoder_mode_i,
                 enc_dir: encoder_dir_i};

  // Software and slave updates restart the counter; a wrap has done so itself.
  count_core u_count (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .cfg_i     (cfg),
    .reload_i  (active_reload_o),
    .psc_i     (active_prescaler_o),
    .restart_i (update_now && !wrap),
    .count_o   (count),
    .dir_o     (hw_dir),
    .step_o    (step),
    .wrap_o    (wrap)
  );

  sample_divider u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .div_i  (ctrl.sampling_clock_divider),
    .tick_o (dts_tick_o)
  );

  // --------------------------------------------------------------------------
  // Interrupt status, enable and outputs
  // --------------------------------------------------------------------------
  always_comb begin
    if (ctrl.center_align_select == `TMR_CAM_DOWN) begin
      cmp_hit = step && count == active_compare_o && hw_dir;  // RULE10
    end else if (ctrl.center_align_select == `TMR_CAM_UP) begin
      cmp_hit = step && count == active_compare_o && !hw_dir; // RULE10
    end else begin
      cmp_hit = step && count == active_compare_o;            // RULE10
    end
  end

  // Sticky bits: a new event in the clear cycle survives the clear.
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_now && adr_i == `TMR_IRQ_CLR_OFS && sel_i[0]) begin
      next_irq_stat = irq_stat & ~dat_i[1:0];
    end
    if (request_now) begin
      next_irq_stat[`TMR_ST_UPDATE_BIT] = 1'b1;
    end
    if (cmp_hit) begin
      next_irq_stat[`TMR_ST_CMP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en         <= `TMR_WORD_RESET;
      irq_stat       <= 2'h0;
      irq_o          <= 1'b0;
      dma_req_o      <= 1'b0;
      update_event_o <= 1'b0;
    end else begin
      if (wr_now && adr_i == `TMR_IRQ_EN_OFS) begin
        irq_en <= merge(irq_en, dat_i, sel_i);
      end
      irq_stat       <= next_irq_stat;
      irq_o          <= |(next_irq_stat & irq_en[1:0]);
      dma_req_o      <= request_now && irq_en[`TMR_EN_DMA_BIT]; // RULE6 RULE7
      update_event_o <= update_now;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence bus_req_s;
    bus_req && !ack_o;
  endsequence

  sequence wrap_free_s;
    wrap && !ctrl.update_inhibit;
  endsequence

  bus_ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req_s |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse after request");
  inhibit_no_update_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    ctrl.update_inhibit |=> !update_event_o)
    else $error("update event while inhibited");
  wrap_gives_update_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    wrap_free_s |=> update_event_o)
    else $error("wrap without update event");
  update_loads_copy_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    update_now && !wr_now |=> active_prescaler_o == $past(psc_pre) && active_compare_o == $past(cmp_pre))
    else $error("active copies not loaded on update");
  all_sources_req_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    update_now && !ctrl.update_request_source && irq_en[`TMR_EN_DMA_BIT] |=> dma_req_o)
    else $error("update request missing");
  wrap_only_req_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    ctrl.update_request_source && !wrap |=> !irq_stat[`TMR_ST_UPDATE_BIT] || $past(irq_stat[`TMR_ST_UPDATE_BIT]))
    else $error("request from filtered source");
  one_shot_stop_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    update_now && ctrl.one_shot_enable && !trig_set |=> !ctrl.counter_run_enable)
    else $error("one-shot did not stop counter");
  trigger_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    trig_set |=> ctrl.counter_run_enable)
    else $error("trigger did not start counter");
  reload_direct_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    wr_now && adr_i == `TMR_RELOAD_OFS && !ctrl.reload_preload_enable && sel_i[1:0] == 2'h3
    |=> active_reload_o == $past(dat_i[15:0]))
    else $error("unbuffered reload write not applied");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    ctrl.reserved == 6'h00)
    else $error("reserved control bits set");
  dir_follows_hw_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    hw_dir_mode |-> ctrl_view.count_direction == hw_dir)
    else $error("direction bit not hardware direction");
  cmp_down_only_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    cmp_hit && ctrl.center_align_select == `TMR_CAM_DOWN |-> hw_dir)
    else $error("compare flag while counting up in down mode");

endmodule

// >>> tb/tb_top.sv
// Self-checking testbench for the timer control register block.
`timescale 1ns/1ps
`include "timer_map.svh"

module tb_top;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, trigger_mode_i, trigger_i, slave_update_i;
  logic        encoder_mode_i, encoder_dir_i, irq_o, dma_req_o, update_event_o, dts_tick_o, ack_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [15:0] active_reload_o, active_prescaler_o, active_compare_o;
  int          n_errors, n_compared, cycles, ev, dm;

  timer_control_register_one u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .trigger_mode_i(trigger_mode_i),
    .trigger_i(trigger_i), .slave_update_i(slave_update_i), .encoder_mode_i(encoder_mode_i),
    .encoder_dir_i(encoder_dir_i), .irq_o(irq_o), .dma_req_o(dma_req_o), .update_event_o(update_event_o),
    .dts_tick_o(dts_tick_o), .active_reload_o(active_reload_o), .active_prescaler_o(active_prescaler_o),
    .active_compare_o(active_compare_o));

  // ----------------------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------------------
  // The 4 ns clock is made by inverting every half period.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // A hang is cut short well above the few hundred cycles the run needs.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d.", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high, then it is released.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'h3;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, rd);
  endtask

  // Counts update events and DMA pulses over a window of edges.
  task automatic watch(input int n);
    ev = 0;
    dm = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (update_event_o === 1'b1) ev++;
      if (dma_req_o === 1'b1) dm++;
    end
  endtask

  task automatic slave_pulse();
    @(posedge clk_i);
    slave_update_i <= 1'b1;
    @(posedge clk_i);
    slave_update_i <= 1'b0;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset_and_reserved();
    wb(1'b0, `TMR_CTRL_OFS, 32'h0, rd);
    chk("ctrl reset", 32'h0000_0000, rd);
    chk("reload reset", 32'h0000_FFFF, {16'h0000, active_reload_o});
    wr(`TMR_CTRL_OFS, 32'h0000_FC10);
    wb(1'b0, `TMR_CTRL_OFS, 32'h0, rd);
    chk("ctrl reserved bits", 32'h0000_0010, rd);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped read", 32'h0000_0000, rd);
    wr(`TMR_CTRL_OFS, 32'h0000_0000);
  endtask

  // Pending copies move to the active side only on a permitted update.
  task automatic t_inhibit_and_load();
    wr(`TMR_PSC_OFS, 32'h0000_0003);
    wr(`TMR_CMP_OFS, 32'h0000_0007);
    wr(`TMR_CTRL_OFS, 32'h0000_0002);
    wr(`TMR_EVENT_OFS, 32'h0000_0001);
    watch(6);
    chk("inhibited trigger events", 32'h0, ev);
    slave_pulse();
    watch(6);
    chk("inhibited slave events", 32'h0, ev);
    chk("psc held", 32'h0, {16'h0000, active_prescaler_o});
    wr(`TMR_CTRL_OFS, 32'h0000_0000);
    wr(`TMR_EVENT_OFS, 32'h0000_0001);
    watch(6);
    chk("software update event", 32'h1, ev);
    chk("psc loaded", 32'h3, {16'h0000, active_prescaler_o});
    chk("cmp loaded", 32'h7, {16'h0000, active_compare_o});
  endtask

  // Request source zero requests on every update; source one drops the requests of software and slave updates.
  task automatic t_request_source();
    wr(`TMR_IRQ_CLR_OFS, 32'h0000_0003);
    wr(`TMR_IRQ_EN_OFS, 32'h0000_0101);
    wr(`TMR_EVENT_OFS, 32'h0000_0001);
    watch(6);
    chk("dma on software update", 32'h1, dm);
    chk("irq on software update", 32'h1, irq_o);
    wr(`TMR_IRQ_CLR_OFS, 32'h0000_0001);
    wb(1'b0, `TMR_IRQ_STAT_OFS, 32'h0, rd);
    chk("status cleared", 32'h0, rd & 32'h1);
    chk("irq dropped", 32'h0, irq_o);
    slave_pulse();
    watch(6);
    chk("dma on slave update", 32'h1, dm);
    wr(`TMR_IRQ_CLR_OFS, 32'h0000_0003);
    wr(`TMR_CTRL_OFS, 32'h0000_0004);
    wr(`TMR_EVENT_OFS, 32'h0000_0001);
    watch(6);
    chk("filtered software event", 32'h1, ev);
    chk("filtered software dma", 32'h0, dm);
    slave_pulse();
    watch(6);
    chk("filtered slave dma", 32'h0, dm);
    wb(1'b0, `TMR_IRQ_STAT_OFS, 32'h0, rd);
    chk("filtered status", 32'h0, rd & 32'h1);
    wr(`TMR_CTRL_OFS, 32'h0000_0000);
    wr(`TMR_IRQ_EN_OFS, 32'h0000_0000);
  endtask

  task automatic t_reload_preload();
    wr(`TMR_RELOAD_OFS, 32'h0000_1234);
    @(posedge clk_i);
    chk("reload direct", 32'h1234, {16'h0000, active_reload_o});
    wr(`TMR_CTRL_OFS, 32'h0000_0080);
    wr(`TMR_RELOAD_OFS, 32'h0000_5678);
    @(posedge clk_i);
    chk("reload buffered", 32'h1234, {16'h0000, active_reload_o});
    wr(`TMR_EVENT_OFS, 32'h0000_0001);
    watch(4);
    chk("reload on update", 32'h5678, {16'h0000, active_reload_o});
    wr(`TMR_CTRL_OFS, 32'h0000_0000);
  endtask

  // A short count with prescaler zero wraps quickly and must stop the counter.
  task automatic t_one_shot();
    wr(`TMR_PSC_OFS, 32'h0000_0000);
    wr(`TMR_EVENT_OFS, 32'h0000_0001);
    wr(`TMR_RELOAD_OFS, 32'h0000_0005);
    wr(`TMR_CTRL_OFS, 32'h0000_0009);
    watch(40);
    chk("one-shot wrap seen", 32'h1, ev);
    wb(1'b0, `TMR_CTRL_OFS, 32'h0, rd);
    chk("one-shot stopped", 32'h0000_0008, rd);
  endtask

  task automatic t_trigger();
    wr(`TMR_CTRL_OFS, 32'h0000_0000);
    @(posedge clk_i);
    trigger_mode_i <= 1'b1;
    trigger_i      <= 1'b1;
    @(posedge clk_i);
    trigger_i      <= 1'b0;
    wb(1'b0, `TMR_CTRL_OFS, 32'h0, rd);
    chk("trigger run enable", 32'h1, rd & 32'h1);
    trigger_mode_i <= 1'b0;
    wr(`TMR_CTRL_OFS, 32'h0000_0000);
  endtask

  // Windows of 16 edges hold a whole number of strobe periods for every code.
  task automatic t_divider();
    int code;
    int ticks;
    for (code = 0; code < 3; code++) begin
      wr(`TMR_CTRL_OFS, 32'(code) << 8);
      repeat (8) @(posedge clk_i);
      ticks = 0;
      repeat (16) begin
        @(posedge clk_i);
        if (dts_tick_o === 1'b1) ticks++;
      end
      chk("sample strobes", 32'(16 >> code), 32'(ticks));
    end
  endtask

  // Compare at zero is only reached counting down, so code 01 flags it and code 10 does not.
  task automatic t_center();
    int code;
    for (code = 1; code < 3; code++) begin
      wr(`TMR_CTRL_OFS, 32'(code) << 5);
      wr(`TMR_CMP_OFS, 32'h0000_0000);
      wr(`TMR_EVENT_OFS, 32'h0000_0001);
      wr(`TMR_IRQ_CLR_OFS, 32'h0000_0003);
      wr(`TMR_CTRL_OFS, (32'(code) << 5) | 32'h0000_0001);
      repeat (30) @(posedge clk_i);
      wr(`TMR_CTRL_OFS, 32'(code) << 5);
      wb(1'b0, `TMR_IRQ_STAT_OFS, 32'h0, rd);
      chk("center compare flag", (code == 1) ? 32'h0000_0002 : 32'h0000_0000, rd & 32'h0000_0002);
    end
    wr(`TMR_CTRL_OFS, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    {cyc_i, stb_i, we_i, trigger_mode_i, trigger_i, slave_update_i, encoder_mode_i, encoder_dir_i} = 8'h00;
    {adr_i, sel_i, dat_i} = '0;
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_and_reserved();
    t_inhibit_and_load();
    t_request_source();
    t_reload_preload();
    t_one_shot();
    t_trigger();
    t_divider();
    t_center();
    summarize();
  end
endmodule
